/* hw/mbm_matrix.v */
// six-master, five-slave bus matrix with per-slave arbiters and APB setup
// assumes masters hold each request until their hready pulse
//
// Contract
// - six masters reach five slaves over parallel independent paths
// - new connection costs one cycle; slave's default master costs none
// - every master has its own address decoder with several mappings
// - remap bit per master steers only that master's decoder
// - no-default policy: idle slave disconnects from every master
// - last-access policy: idle slave keeps the most recent requester
// - fixed policy: idle slave joins fixed owner, changed only by software
// - per slave: 2-bit policy selector, 4-bit fixed owner number
// - one separate arbiter for each slave
// - per-slave scheme: round-robin or fixed priority, round-robin at reset
// - regrant only on idle, single, burst end or expired slot
// - open burst split per master: never, 1, 4, 8 or 16 beats
// - infinite split: open bursts never broken at predicted ends
// - slot counter loads at burst start, decrements every cycle
// - slot counter zero allows regrant after current beat
// - round-robin: lowest number first, then rotating order
// - round-robin, no default: first burst access pays one cycle
// - round-robin, last access: previous master pays nothing
// - round-robin, fixed default: fixed owner pays nothing
// - fixed priority: highest value wins, ties to highest master number
// - each slave holds a programmable priority per master
// - split codes: 0 infinite, 1 single, 2 four, 3 eight, 4 sixteen
// - policy codes: 0 none, 1 last, 2 fixed
// - fixed owner without a path behaves as no-default policy
// - scheme codes: 0 round-robin, 1 fixed priority, 2 and 3 reserved
//
// The placing of the registers and the APB slave port were decided locally.
`include "mbm_regs.vh"

module mbm_matrix #(
  parameter AW = 32,
  parameter DW = 32
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [11:0] m_htrans,
  input wire [6*AW-1:0] m_haddr,
  input wire [5:0] m_hwrite,
  input wire [17:0] m_hsize,
  input wire [17:0] m_hburst,
  input wire [6*DW-1:0] m_hwdata,
  output reg [5:0] m_hready,
  output reg [5:0] m_hresp,
  output reg [6*DW-1:0] m_hrdata,
  output reg [4:0] s_hsel,
  output reg [5*AW-1:0] s_haddr,
  output reg [9:0] s_htrans,
  output reg [4:0] s_hwrite,
  output reg [14:0] s_hsize,
  output reg [14:0] s_hburst,
  output reg [5*DW-1:0] s_hwdata,
  output reg [14:0] s_hmaster,
  input wire [4:0] s_hreadyout,
  input wire [4:0] s_hresp,
  input wire [5*DW-1:0] s_hrdata
);

  // ****************************************
  // decode and arbitration functions
  // ****************************************

  // boot region is steered by the remap bit
  function [2:0] dec_fn;
    input [3:0] region;
    input remap;
    begin
      if (region == 4'h0)
        dec_fn = remap ? `MBM_BOOT_REMAP_SLV : `MBM_BOOT_SLV;
      else if (region > 4'h4)
        dec_fn = 3'h4;
      else
        dec_fn = region[2:0];
    end
  endfunction

  function [2:0] pick_fn;
    input [5:0] req;
    input [2:0] last;
    input by_prio;
    input [31:0] pri;
    integer i;
    integer t;
    reg [2:0] k;
    reg found;
    reg [1:0] best;
    begin
      pick_fn = `MBM_NO_OWNER;
      found = 1'b0;
      best = 2'h0;
      for (i = 0; i < 6; i = i + 1)
      begin
        if (by_prio)
          t = i;
        else if (last > 3'h5)
          t = i;
        else
          t = (last + 1 + i) % 6;
        k = t[2:0];
        if (by_prio)
        begin
          if (req[k] && (!found || pri[4*k +: 2] >= best))
          begin
            pick_fn = k;
            best = pri[4*k +: 2];
            found = 1'b1;
          end
        end
        else if (req[k] && !found)
        begin
          pick_fn = k;
          found = 1'b1;
        end
      end
    end
  endfunction

  function [2:0] dflt_fn;
    input [1:0] pol;
    input [3:0] fix;
    input [2:0] last;
    begin
      case (pol)
        `MBM_POL_LAST: dflt_fn = last;
        `MBM_POL_FIXED: dflt_fn = (fix < 4'h6) ? fix[2:0] : `MBM_NO_OWNER;
        default: dflt_fn = `MBM_NO_OWNER;
      endcase
    end
  endfunction

  // {break enabled, beat mask}; the beat count wraps at sixteen
  function [4:0] bmask_fn;
    input [2:0] hb;
    input [2:0] split;
    begin
      case (hb)
        `MBM_BURST_SINGLE: bmask_fn = 5'h10;
        `MBM_BURST_INCR:
          case (split)
            `MBM_SPLIT_1: bmask_fn = 5'h10;
            `MBM_SPLIT_4: bmask_fn = 5'h13;
            `MBM_SPLIT_8: bmask_fn = 5'h17;
            `MBM_SPLIT_16: bmask_fn = 5'h1F;
            default: bmask_fn = 5'h00;
          endcase
        3'h2, 3'h3: bmask_fn = 5'h13;
        3'h4, 3'h5: bmask_fn = 5'h17;
        default: bmask_fn = 5'h1F;
      endcase
    end
  endfunction

  // ****************************************
  // configuration registers
  // ****************************************

  reg [31:0] mcfg_reg [0:5];
  reg [31:0] scfg_reg [0:4];
  reg [31:0] pri_reg [0:4];
  reg [31:0] remap_reg;
  reg [2:0] owner_reg [0:4];
  reg [2:0] last_reg [0:4];
  reg [7:0] slot_reg [0:4];
  reg [3:0] beat_reg [0:4];
  reg [4:0] brk_reg;
  wire [14:0] owner_bus;
  reg [31:0] rd_next;
  reg hit_next;
  integer i;
  integer j;
  integer c;

  // own loop index: a shared one would be driven from two processes
  always @*
  begin
    rd_next = 32'h0000_0000;
    hit_next = 1'b0;
    for (c = 0; c < 6; c = c + 1)
      if (paddr == `MBM_MCFG_BASE + 4*c)
      begin
        rd_next = mcfg_reg[c];
        hit_next = 1'b1;
      end
    for (c = 0; c < 5; c = c + 1)
    begin
      if (paddr == `MBM_SCFG_BASE + 4*c)
      begin
        rd_next = scfg_reg[c];
        hit_next = 1'b1;
      end
      if (paddr == `MBM_PRAS_BASE + `MBM_PRAS_STEP*c)
      begin
        rd_next = pri_reg[c];
        hit_next = 1'b1;
      end
    end
    if (paddr == `MBM_REMAP_OFS)
    begin
      rd_next = remap_reg;
      hit_next = 1'b1;
    end
    if (paddr == `MBM_STATUS_OFS)
    begin
      rd_next = {17'h0, owner_bus};
      hit_next = 1'b1;
    end
  end

  // one wait state: answer is ready in the second access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      remap_reg <= 32'h0000_0000;
      for (i = 0; i < 6; i = i + 1)
        mcfg_reg[i] <= 32'h0000_0000;
      for (i = 0; i < 5; i = i + 1)
      begin
        pri_reg[i] <= 32'h0000_0000;
        scfg_reg[i] <= `MBM_SCFG_RST;
      end
      scfg_reg[0] <= `MBM_SCFG0_RST;
      scfg_reg[1] <= `MBM_SCFG1_RST;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rd_next;
        pslverr <= ~hit_next;
      end
      if (psel & penable & pready & pwrite)
      begin
        for (i = 0; i < 6; i = i + 1)
          if (paddr == `MBM_MCFG_BASE + 4*i)
            mcfg_reg[i] <= pwdata & `MBM_MCFG_MASK;
        for (i = 0; i < 5; i = i + 1)
        begin
          if (paddr == `MBM_SCFG_BASE + 4*i)
            scfg_reg[i] <= pwdata & `MBM_SCFG_MASK;
          if (paddr == `MBM_PRAS_BASE + `MBM_PRAS_STEP*i)
            pri_reg[i] <= pwdata & `MBM_PRAS_MASK;
        end
        if (paddr == `MBM_REMAP_OFS)
          remap_reg <= pwdata & `MBM_REMAP_MASK;
      end
    end
  end

  // ****************************************
  // per-master decoders
  // ****************************************

  wire [17:0] m_sel;
  wire [29:0] req_vec;
  wire [29:0] done_ms;
  wire [4:0] arb_ok;
  wire [4:0] issue;
  wire [14:0] pick;
  wire [14:0] dflt;
  wire [4:0] end_beat;
  wire [4:0] own_nonseq;

  genvar gm;
  genvar gs;
  generate
    for (gm = 0; gm < 6; gm = gm + 1)
    begin : dec
      assign m_sel[3*gm +: 3] =
        dec_fn(m_haddr[AW*gm+AW-4 +: 4], remap_reg[gm]);
    end

    // ****************************************
    // per-slave arbiters
    // ****************************************

    for (gs = 0; gs < 5; gs = gs + 1)
    begin : arb
      wire [2:0] own = owner_reg[gs];
      wire own_ok = own < 3'h6;
      wire [2:0] own_i = own_ok ? own : 3'h0;
      wire [5:0] req = req_vec[6*gs +: 6];
      wire own_req = own_ok & req[own_i];
      wire [31:0] cfg = scfg_reg[gs];
      wire [4:0] bm = bmask_fn(m_hburst[3*own_i +: 3], mcfg_reg[own_i][2:0]);
      wire done = s_hsel[gs] & s_hreadyout[gs];
      for (gm = 0; gm < 6; gm = gm + 1)
      begin : rq
        assign req_vec[6*gs+gm] =
          m_htrans[2*gm+1] & (m_sel[3*gm +: 3] == gs);
        assign done_ms[6*gs+gm] = done & own_ok & (own == gm);
      end
      // a fresh pick only when the slave is between beats and free to move
      assign arb_ok[gs] = ~s_hsel[gs] & (~own_req | brk_reg[gs]);
      // the connected master goes straight out, no arbitration cycle
      assign issue[gs] = ~s_hsel[gs] & own_req & ~brk_reg[gs] &
        ~m_hready[own_i];
      assign pick[3*gs +: 3] = pick_fn(req, last_reg[gs],
        cfg[`MBM_ARB_LSB +: 2] == `MBM_ARB_FIXED, pri_reg[gs]);
      assign dflt[3*gs +: 3] = dflt_fn(cfg[`MBM_POL_LSB +: 2],
        cfg[`MBM_FIX_LSB +: 4], last_reg[gs]);
      assign end_beat[gs] = (bm[4] & ((beat_reg[gs] & bm[3:0]) == 4'h0)) |
        (slot_reg[gs] == 8'h00);
      assign own_nonseq[gs] =
        m_htrans[2*own_i +: 2] == `MBM_TRANS_NONSEQ;
      assign owner_bus[3*gs +: 3] = own;
    end
  endgenerate

  // ****************************************
  // slave side state and forwarding
  // ****************************************

  // outputs are registered, so a beat reaches the slave one edge after issue
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_hsel <= 5'h00;
      s_haddr <= {5*AW{1'b0}};
      s_htrans <= 10'h000;
      s_hwrite <= 5'h00;
      s_hsize <= 15'h0000;
      s_hburst <= 15'h0000;
      s_hwdata <= {5*DW{1'b0}};
      s_hmaster <= 15'h7FFF;
      brk_reg <= 5'h00;
      for (j = 0; j < 5; j = j + 1)
      begin
        owner_reg[j] <= `MBM_NO_OWNER;
        last_reg[j] <= `MBM_NO_OWNER;
        slot_reg[j] <= 8'h00;
        beat_reg[j] <= 4'h0;
      end
    end
    else
    begin
      for (j = 0; j < 5; j = j + 1)
      begin
        if (arb_ok[j])
        begin
          brk_reg[j] <= 1'b0;
          if (|req_vec[6*j +: 6])
            owner_reg[j] <= pick[3*j +: 3];
          else
            owner_reg[j] <= dflt[3*j +: 3];
        end
        if (issue[j])
        begin
          s_hsel[j] <= 1'b1;
          s_haddr[AW*j +: AW] <= m_haddr[AW*owner_reg[j] +: AW];
          s_htrans[2*j +: 2] <= m_htrans[2*owner_reg[j] +: 2];
          s_hwrite[j] <= m_hwrite[owner_reg[j]];
          s_hsize[3*j +: 3] <= m_hsize[3*owner_reg[j] +: 3];
          s_hburst[3*j +: 3] <= m_hburst[3*owner_reg[j] +: 3];
          s_hwdata[DW*j +: DW] <= m_hwdata[DW*owner_reg[j] +: DW];
          s_hmaster[3*j +: 3] <= owner_reg[j];
          last_reg[j] <= owner_reg[j];
          beat_reg[j] <= own_nonseq[j] ? 4'h1 : beat_reg[j] + 4'h1;
        end
        if (issue[j] & own_nonseq[j])
          slot_reg[j] <= scfg_reg[j][`MBM_SLOT_LSB +: 8];
        else if (slot_reg[j] != 8'h00)
          slot_reg[j] <= slot_reg[j] - 8'h01;
        if (s_hsel[j] & s_hreadyout[j])
        begin
          s_hsel[j] <= 1'b0;
          s_htrans[2*j +: 2] <= 2'h0;
          brk_reg[j] <= end_beat[j];
        end
      end
    end
  end

  // ****************************************
  // master side answers
  // ****************************************

  integer k;
  integer n;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_hready <= 6'h00;
      m_hresp <= 6'h00;
      m_hrdata <= {6*DW{1'b0}};
    end
    else
    begin
      for (k = 0; k < 6; k = k + 1)
      begin
        m_hready[k] <= 1'b0;
        for (n = 0; n < 5; n = n + 1)
          if (done_ms[6*n+k])
          begin
            m_hready[k] <= 1'b1;
            m_hresp[k] <= s_hresp[n];
            m_hrdata[DW*k +: DW] <= s_hrdata[DW*n +: DW];
          end
      end
    end
  end

endmodule // mbm_matrix

/* hw/mbm_regs.vh */
// constants of the six-by-five bus matrix: sizes, register map, fields
// assumes a 32-bit APB register bus and AHB-Lite style layers
`ifndef MBM_REGS_VH
`define MBM_REGS_VH

`define MBM_NUM_M 6
`define MBM_NUM_S 5
`define MBM_NO_OWNER 3'h7

// register byte offsets
`define MBM_MCFG_BASE 12'h000
`define MBM_SCFG_BASE 12'h040
`define MBM_PRAS_BASE 12'h080
`define MBM_PRAS_STEP 8
`define MBM_REMAP_OFS 12'h100
`define MBM_STATUS_OFS 12'h110

// field layout
`define MBM_MCFG_MASK 32'h0000_0007
`define MBM_SCFG_MASK 32'h033F_00FF
`define MBM_PRAS_MASK 32'h0033_3333
`define MBM_REMAP_MASK 32'h0000_003F
`define MBM_SLOT_LSB 0
`define MBM_POL_LSB 16
`define MBM_FIX_LSB 18
`define MBM_ARB_LSB 24

// reset values
`define MBM_SCFG0_RST 32'h0001_0010
`define MBM_SCFG1_RST 32'h0005_0010
`define MBM_SCFG_RST 32'h0000_0010

// default master policies and arbitration schemes
`define MBM_POL_NONE 2'h0
`define MBM_POL_LAST 2'h1
`define MBM_POL_FIXED 2'h2
`define MBM_ARB_RR 2'h0
`define MBM_ARB_FIXED 2'h1

// open burst split selector codes
`define MBM_SPLIT_INF 3'h0
`define MBM_SPLIT_1 3'h1
`define MBM_SPLIT_4 3'h2
`define MBM_SPLIT_8 3'h3
`define MBM_SPLIT_16 3'h4

// ahb codes and boot decode
`define MBM_TRANS_NONSEQ 2'h2
`define MBM_BURST_SINGLE 3'h0
`define MBM_BURST_INCR 3'h1
`define MBM_BOOT_SLV 3'h0
`define MBM_BOOT_REMAP_SLV 3'h1

`endif

/* verif/mbm_matrix_sva.sv */
// port assertions for the six-by-five bus matrix
// bound to mbm_matrix from the bench top; one clock domain, pclk
module mbm_matrix_sva #(
  parameter AW = 32,
  parameter DW = 32
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire [11:0] m_htrans,
  input wire [5:0] m_hready,
  input wire [4:0] s_hsel,
  input wire [5*AW-1:0] s_haddr,
  input wire [14:0] s_hmaster,
  input wire [4:0] s_hreadyout
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence apb_wait;
    psel && penable && !pready;
  endsequence
  sequence beat_open0;
    s_hsel[0] && !s_hreadyout[0];
  endsequence
  sequence beat_done0;
    s_hsel[0] && s_hreadyout[0];
  endsequence
  property served(m);
    $rose(m_htrans[2*m+1]) |-> ##[1:200] m_hready[m];
  endproperty
  a_apb_one_wait: assert property (apb_wait |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");
  a_grant_held: assert property (beat_open0 |=> s_hsel[0] &&
    $stable(s_hmaster[2:0]) && $stable(s_haddr[AW-1:0]))
    else $error("slave 0 owner or address moved mid beat");
  a_owner_valid: assert property (s_hsel[2] |-> s_hmaster[8:6] < 3'h6)
    else $error("slave 2 selected without a real master");
  a_sel_has_req: assert property ($rose(s_hsel[3]) |->
    m_htrans[2*s_hmaster[11:9]+1])
    else $error("slave 3 selected for an idle master");
  a_done_ack: assert property (beat_done0 |=> !s_hsel[0] &&
    m_hready[$past(s_hmaster[2:0])])
    else $error("slave 0 beat end not passed to its master");
  a_ready_pulse: assert property (m_hready[1] |->
    $past(m_htrans[3]) ##1 !m_hready[1])
    else $error("master 1 ready without request or too long");
  a_no_starve0: assert property (served(0))
    else $error("master 0 left waiting");
  a_no_starve5: assert property (served(5))
    else $error("master 5 left waiting");
endmodule  // mbm_matrix_sva

/* verif/mbm_slave_model.sv */
// behavioural model of the five slaves behind the matrix
// each answers a beat at once or after three waits, as the bench asks
module mbm_slave_model (
  input wire pclk,
  input wire presetn,
  input wire [4:0] s_hsel,
  input wire [159:0] s_haddr,
  input wire [4:0] slow,
  output wire [4:0] s_hreadyout,
  output wire [4:0] s_hresp,
  output wire [159:0] s_hrdata
);
  // ****************************************
  // slaves
  // ****************************************
  logic [31:0] ptn;
  // noise outside the ready cycle, so a stale word never passes
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      ptn <= 32'h0;
    else
      ptn <= {ptn[30:0], ~ptn[31]};
  assign s_hresp = 5'h0;
  for (genvar s = 0; s < 5; s++)
  begin : g_slv
    logic [1:0] cnt;
    assign s_hreadyout[s] = s_hsel[s] && (!slow[s] || cnt == 2'h3);
    assign s_hrdata[32*s+:32] = s_hreadyout[s] ?
      s_haddr[32*s+:32] ^ 32'h5A5A_5A5A : ptn;
    always @(posedge pclk or negedge presetn)
      if (!presetn)
        cnt <= 2'h0;
      else
        cnt <= (s_hsel[s] && !s_hreadyout[s]) ? cnt + 2'h1 : 2'h0;
  end
endmodule  // mbm_slave_model

/* verif/mbm_matrix_tb.sv */
// self-checking bench for the six-by-five bus matrix
// drives APB and six masters with single beats and open-length bursts; slave models answer
module mbm_matrix_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0, m_htrans = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [191:0] m_haddr = 192'h0, m_hwdata = 192'h0;
  logic [5:0] m_hwrite = 6'h0;
  logic [17:0] m_hsize = 18'h0, m_hburst = 18'h0;
  logic [4:0] slow = 5'h0, sel_q = 5'h0;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [5:0] m_hready, m_hresp;
  wire [191:0] m_hrdata;
  wire [4:0] s_hsel, s_hwrite, s_hreadyout, s_hresp;
  wire [159:0] s_haddr, s_hwdata, s_hrdata;
  wire [9:0] s_htrans;
  wire [14:0] s_hsize, s_hburst, s_hmaster;
  int n_mismatch = 0, tests_run = 0, mm;
  int wc[6];
  int gq[$], lq[$];

  always #20 pclk = ~pclk;

  mbm_matrix dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .m_htrans(m_htrans), .m_haddr(m_haddr), .m_hwrite(m_hwrite),
    .m_hsize(m_hsize), .m_hburst(m_hburst), .m_hwdata(m_hwdata),
    .m_hready(m_hready), .m_hresp(m_hresp), .m_hrdata(m_hrdata),
    .s_hsel(s_hsel), .s_haddr(s_haddr), .s_htrans(s_htrans),
    .s_hwrite(s_hwrite), .s_hsize(s_hsize), .s_hburst(s_hburst),
    .s_hwdata(s_hwdata), .s_hmaster(s_hmaster),
    .s_hreadyout(s_hreadyout), .s_hresp(s_hresp), .s_hrdata(s_hrdata));
  mbm_slave_model slv_u (.pclk(pclk), .presetn(presetn), .s_hsel(s_hsel),
    .s_haddr(s_haddr), .slow(slow), .s_hreadyout(s_hreadyout),
    .s_hresp(s_hresp), .s_hrdata(s_hrdata));

  // ****************************************
  // grant monitor: slave, master, cycles waited
  // ****************************************
  always @(posedge pclk)
  begin
    for (int s = 0; s < 5; s++)
      if (s_hsel[s] === 1'b1 && sel_q[s] === 1'b0)
      begin
        mm = s_hmaster[3*s+:3];
        gq.push_back(8 * s + mm);
        lq.push_back(wc[mm]);
        chk(s_haddr[32*s+:32], m_haddr[32*mm+:32]);
        chk(s_hwdata[32*s+:32], m_hwdata[32*mm+:32]);
        chk(s_htrans[2*s+:2], m_htrans[2*mm+:2]);
        chk(s_hsize[3*s+:3], m_hsize[3*mm+:3]);
        chk(s_hburst[3*s+:3], m_hburst[3*mm+:3]);
        chk(s_hwrite[s], m_hwrite[mm]);
      end
    sel_q <= s_hsel;
    for (int m = 0; m < 6; m++)
      wc[m] <= m_htrans[2*m+1] ? wc[m] + 1 : 0;
  end

  task automatic tally_and_finish(input int extra);
    n_mismatch += extra;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++)
      @(posedge pclk);
    if (k == 20)
      tally_and_finish(1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  // a read beat; the request stands until this master's ready edge
  task automatic acc(input int m, input logic [31:0] a);
    int k;
    @(posedge pclk);
    m_haddr[32*m+:32] <= a;
    m_htrans[2*m+:2] <= 2'h2;
    for (k = 0; k < 300; k++)
    begin
      @(posedge pclk);
      if (m_hready[m] === 1'b1)
        break;
    end
    if (k == 300)
      tally_and_finish(1);
    chk(m_hrdata[32*m+:32], a ^ 32'h5A5A_5A5A);
    chk(m_hresp[m], 1'b0);
    m_htrans[2*m+:2] <= 2'h0;
  endtask

  // an open-length burst; every beat is held until this master's ready
  task automatic bst(input int m, input logic [31:0] a, input int n);
    int k;
    @(posedge pclk);
    m_hburst[3*m+:3] <= 3'h1;
    for (int b = 0; b < n; b++)
    begin
      m_haddr[32*m+:32] <= a + 4 * b;
      m_htrans[2*m+:2] <= (b == 0) ? 2'h2 : 2'h3;
      for (k = 0; k < 300; k++)
      begin
        @(posedge pclk);
        if (m_hready[m] === 1'b1)
          break;
      end
      if (k == 300)
        tally_and_finish(1);
      chk(m_hrdata[32*m+:32], (a + 4 * b) ^ 32'h5A5A_5A5A);
    end
    m_htrans[2*m+:2] <= 2'h0;
    m_hburst[3*m+:3] <= 3'h0;
  endtask

  // lat below zero: waiting time not judged
  task automatic expg(input int s, input int m, input int lat);
    int w;
    if (gq.size() == 0)
      chk(32'h0, 32'h1);
    else
    begin
      chk(gq.pop_front(), 8 * s + m);
      w = lq.pop_front();
      if (lat >= 0)
        chk(w, lat);
    end
  endtask

  task automatic one(input int m, input logic [31:0] a, input int s,
    input int lat);
    acc(m, a);
    expg(s, m, lat);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    int m, s, e0, e1;
    void'($urandom(2));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h040, 32'h0001_0010, 1'b0);
    rd(12'h044, 32'h0005_0010, 1'b0);
    rd(12'h04C, 32'h0000_0010, 1'b0);
    rd(12'h0A0, 32'h0, 1'b0);
    rd(12'h100, 32'h0, 1'b0);
    rd(12'h110, 32'h0000_7FFF, 1'b0);
    wr(12'h084, 32'hFFFF_FFFF);
    rd(12'h084, 32'h0, 1'b1);
    wr(12'h014, 32'hFFFF_FFFF);
    rd(12'h014, 32'h0000_0007, 1'b0);
    one(0, 32'h0000_0010, 0, 2);
    one(0, 32'h0000_0014, 0, 1);
    one(1, 32'h0000_0018, 0, 2);
    one(1, 32'h0000_001C, 0, 1);
    one(0, 32'h0000_0020, 0, 2);
    fork
      acc(0, 32'h4000_0100);
      acc(2, 32'h4000_0200);
      acc(5, 32'h4000_0300);
    join
    expg(4, 0, -1);
    expg(4, 2, -1);
    expg(4, 5, -1);
    one(3, 32'h4000_0400, 4, 2);
    one(3, 32'h4000_0404, 4, 2);
    fork
      acc(1, 32'h4000_0500);
      acc(4, 32'h4000_0600);
    join
    expg(4, 4, -1);
    expg(4, 1, -1);
    wr(12'h04C, 32'h000E_0010);
    one(3, 32'h3000_0000, 3, 1);
    one(1, 32'h3000_0004, 3, 2);
    one(3, 32'h3000_0008, 3, 1);
    wr(12'h04C, 32'h001A_0010);
    one(3, 32'h3000_000C, 3, 2);
    one(3, 32'h3000_0010, 3, 2);
    wr(12'h048, 32'h0100_0010);
    wr(12'h090, 32'h0003_3010);
    fork
      acc(1, 32'h2000_0000);
      acc(3, 32'h2000_0004);
      acc(4, 32'h2000_0008);
    join
    expg(2, 4, -1);
    expg(2, 3, -1);
    expg(2, 1, -1);
    wr(12'h100, 32'h0000_0004);
    one(2, 32'h0000_0040, 1, -1);
    one(0, 32'h0000_0044, 0, -1);
    // pass 0: split every four beats; pass 1: no split, slot limit of 4
    wr(12'h000, 32'h0000_0002);
    for (int c = 0; c < 2; c++)
    begin
      one(1, 32'h4000_0A00, 4, -1);
      fork
        bst(0, 32'h4000_0800, 8);
        acc(1, 32'h4000_0900);
      join
      for (int b = 0; b < 9; b++)
        expg(4, (b == 4 - c) ? 1 : 0, -1);
      wr(12'h000, 32'h0000_0000);
      wr(12'h050, 32'h0000_0004);
    end
    for (int i = 0; i < 12; i++)
    begin
      slow <= 5'($urandom);
      m_hwdata <= {6{$urandom}};
      m_hsize <= 18'($urandom);
      m_hwrite <= 6'($urandom);
      m = $urandom % 6;
      s = $urandom % 5;
      fork
        acc(m, {4'(s), 28'($urandom)});
        acc((m + 1) % 6, {4'((s + 1) % 5), 28'($urandom)});
      join
      e0 = 8 * s + m;
      e1 = 8 * ((s + 1) % 5) + (m + 1) % 6;
      chk(gq.size(), 2);
      chk(gq[0] + gq[1], e0 + e1);
      chk(gq[0] * gq[1], e0 * e1);
      gq.delete();
      lq.delete();
    end
    tally_and_finish(0);
  end
endmodule  // mbm_matrix_tb

bind mbm_matrix mbm_matrix_sva #(.AW(AW), .DW(DW)) sva_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .m_htrans(m_htrans), .m_hready(m_hready), .s_hsel(s_hsel),
  .s_haddr(s_haddr), .s_hmaster(s_hmaster), .s_hreadyout(s_hreadyout));
